// >>> uart_dma_pkg.sv
/*
 * Shared constants for the serial port with receive DMA: register offsets,
 * control and status field positions, reset values, bit timing and states.
 * Assumes a 32-bit AHB-Lite register bus decoded on the low address byte.
 */
package uart_dma_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DATA   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CTRL   = 8'h08;
	localparam logic [7:0] OFS_DIV_HI = 8'h0C;
	localparam logic [7:0] OFS_DIV_LO = 8'h10;
	localparam logic [3:0] DMA_BLK_LO = 4'h2;	// Channel a at 0x20, b 0x30, c 0x40
	localparam logic [3:0] DMA_BLK_HI = 4'h4;
	localparam logic [1:0] SUB_HIGH   = 2'h0;
	localparam logic [1:0] SUB_START  = 2'h1;
	localparam logic [1:0] SUB_END    = 2'h2;
	localparam logic [1:0] SUB_CTRL   = 2'h3;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_TEN   = 0;
	localparam int CTRL_REN   = 1;
	localparam int CTRL_PEN   = 2;
	localparam int CTRL_ODD   = 3;
	localparam int CTRL_STOP2 = 4;
	localparam int CTRL_CTSE  = 5;
	localparam int CTRL_MPEN  = 6;
	localparam int CTRL_MPBIT = 7;
	localparam int CTRL_RTS   = 8;
	localparam int ST_RX_FULL = 0;
	localparam int ST_TX_RDY  = 1;
	localparam int ST_FRM     = 2;
	localparam int ST_PAR     = 3;
	localparam int ST_OVR     = 4;
	localparam int ST_BRK     = 5;
	localparam int ST_CTS     = 6;
	localparam int ST_TX_BUSY = 7;
	localparam int ST_BIT9    = 8;
	localparam int DCTL_EN    = 0;
	localparam int DCTL_SRC   = 1;
	localparam int DCTL_DONE  = 2;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [8:0]  CTRL_RESET = 9'h100;	// Pin for request-to-send high
	localparam logic [15:0] DIV_RESET  = 16'h0001;
	localparam logic [11:0] ADDR_RESET = 12'h000;
	localparam logic [3:0]  TICK_LAST  = 4'hF;	// Sixteen ticks per bit
	localparam logic [3:0]  TICK_MID   = 4'h7;	// Mid-bit of the start bit
	localparam logic [2:0]  BIT_LAST   = 3'h7;	// Eight data bits
	localparam int          NUM_CHAN   = 3;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BREAK} rx_state_e;

	// Parity bit that makes the count of ones even, or odd when odd_mode
	function automatic logic parity_of(input logic [7:0] d, input logic odd_mode);
		parity_of = (^d) ^ odd_mode;
	endfunction

endpackage

// >>> dma_channel.sv
/*
 * One peripheral DMA channel pointer: walks a byte buffer from its start
 * address to its end address, one step per transfer, then wraps.
 * Assumes the parent arbitrates the memory port and reloads on set-up.
 */
`timescale 1ns/10ps
module dma_channel import uart_dma_pkg::*; (
	input  wire logic        mclk,		// System clock
	input  wire logic        srst,		// Synchronous reset
	input  wire logic        load,		// Reload pointer from start
	input  wire logic        advance,	// One byte written at cur_addr
	input  wire logic [11:0] start_addr,	// First buffer byte
	input  wire logic [11:0] end_addr,	// Last buffer byte
	output logic      [11:0] cur_addr,	// Next byte to write
	output logic             at_end		// Pointer sits on the end byte
);

	// ----------------------------------------------------------------
	// Buffer pointer
	// ----------------------------------------------------------------
	logic [11:0] ptr_reg;

	assign cur_addr = ptr_reg;
	assign at_end   = (ptr_reg == end_addr);

	// Reload, step, or wrap after the end byte
	always_ff @(posedge mclk) begin
		if (srst) begin
			ptr_reg <= ADDR_RESET;
		end else if (load) begin
			ptr_reg <= start_addr;
		end else if (advance) begin
			ptr_reg <= at_end ? start_addr : ptr_reg + 12'h001;
		end
	end

endmodule

// >>> uart_dma_top.sv
/*
 * Serial transmitter and receiver with a shared 16x baud divisor, parity,
 * 9-bit mode, flow control, and three DMA channels writing one RAM port.
 * Assumes an AHB-Lite master on the register bus and synchronous rxd/cts_n.
 */
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
// Functional notes
// - Eight data bits, least significant first
// - One low start, one or two stops
// - Optional parity bit after data, even/odd
// - Parity makes count of ones even/odd
// - Parity mismatch between ends flags errors
// - Flag framing, parity, overrun and break
// - Rate is clock over sixteen times divisor
// - Both directions share divisor and format
// - Separate transmit and receive enables
// - Receive and transmit interrupts kept separate
// - Selectable 9-bit multiprocessor character format
// - Clear-to-send pauses the transmitter
// - Character arriving on full buffer discarded
// - Three channels, third for converter
// - Channel copies received bytes into RAM
// - Interrupt after end byte written
// - Twelve-bit addresses from shared high nibbles
`timescale 1ns/10ps
module uart_dma_top import uart_dma_pkg::*; (
	input  wire logic        mclk,		// System clock, 20 MHz
	input  wire logic        srst,		// Synchronous reset
	input  wire logic        hsel,		// AHB slave select
	input  wire logic [31:0] haddr,		// AHB address
	input  wire logic [1:0]  htrans,	// AHB transfer type
	input  wire logic        hwrite,	// AHB write
	input  wire logic [2:0]  hsize,		// AHB size, word only
	input  wire logic [31:0] hwdata,	// AHB write data
	input  wire logic        hready,	// AHB bus ready
	output logic      [31:0] hrdata,	// AHB read data
	output logic             hreadyout,	// Never inserts waits
	output logic             hresp,		// Always OKAY
	input  wire logic        rxd,		// Serial input
	output logic             txd,		// Serial output
	input  wire logic        cts_n,		// Clear to send, low active
	output logic             rts_n,		// Request to send pin
	output logic             irq_rx,	// Character waiting
	output logic             irq_tx,	// Transmit buffer free
	output logic [2:0]       irq_dma,	// Buffer full per channel
	input  wire logic        conv_valid,	// Converter byte offered
	input  wire logic [7:0]  conv_data,	// Converter byte
	output logic             conv_ready,	// Converter byte taken
	output logic             mem_we,	// RAM write strobe
	output logic      [11:0] mem_addr,	// RAM byte address
	output logic      [7:0]  mem_wdata	// RAM write data
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic [8:0]  ctrl_reg;
	logic [7:0]  div_hi_reg, div_lo_reg;
	logic [15:0] baud_cnt_reg;
	logic [7:0]  tx_buf_reg, tx_shift_reg;
	logic        tx_full_reg, tx_nine_reg, txd_reg;
	logic [3:0]  tx_tcnt_reg, rx_tcnt_reg;
	logic [2:0]  tx_bitcnt_reg, rx_bitcnt_reg;
	tx_state_e   tx_state_reg;
	rx_state_e   rx_state_reg;
	logic [7:0]  rx_shift_reg, rx_buf_reg;
	logic        rx_nine_reg, rx_bit9_reg, rx_full_reg;
	logic        frm_reg, par_reg, ovr_reg, brk_reg;
	logic [7:0]  dma_high_reg [NUM_CHAN];
	logic [7:0]  dma_start_reg [NUM_CHAN];
	logic [7:0]  dma_end_reg [NUM_CHAN];
	logic [2:0]  dma_en_reg, dma_src_reg, dma_done_reg, dma_load_reg;
	logic        mem_we_reg;
	logic [11:0] mem_addr_reg;
	logic [7:0]  mem_wdata_reg;
	logic [11:0] ch_addr [NUM_CHAN];
	logic [2:0]  ch_end, dma_req, dma_fire;
	logic [15:0] baud_divisor, div_last;
	logic [8:0]  status;
	logic [31:0] rd_mux, dma_word;
	logic [1:0]  rd_ch, wr_ch;
	logic        addr_ok, in_map, rd_go, rx_take, tick, par_slot, cts_ok;
	logic        tx_load, tx_bit_end, rx_bit_end, wr_dma, rd_dma;
	logic        wr_data, wr_status, wr_ctrl, wr_div_hi, wr_div_lo;

	// Channel block decode, shared by read and write paths
	function automatic logic dma_hit(input logic [7:0] a);
		dma_hit = (a[7:4] >= DMA_BLK_LO) && (a[7:4] <= DMA_BLK_HI);
	endfunction

	function automatic logic [1:0] dma_idx(input logic [7:0] a);
		dma_idx = 2'(a[7:4] - DMA_BLK_LO);
	endfunction

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	// Address phase decode; no wait states, always OKAY
	assign addr_ok   = hsel & hready & htrans[1];
	assign in_map    = (haddr[31:8] == 24'h0);
	assign rd_go     = addr_ok & ~hwrite & in_map;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// Data phase write strobes
	assign wr_data   = wr_pend_reg && (wr_addr_reg == OFS_DATA);
	assign wr_status = wr_pend_reg && (wr_addr_reg == OFS_STATUS);
	assign wr_ctrl   = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
	assign wr_div_hi = wr_pend_reg && (wr_addr_reg == OFS_DIV_HI);
	assign wr_div_lo = wr_pend_reg && (wr_addr_reg == OFS_DIV_LO);
	assign wr_dma    = wr_pend_reg && dma_hit(wr_addr_reg);
	assign wr_ch     = dma_idx(wr_addr_reg);

	// Read selection, registered into the data phase
	assign rd_dma   = dma_hit(haddr[7:0]);
	assign rd_ch    = dma_idx(haddr[7:0]);
	assign dma_word = (haddr[3:2] == SUB_HIGH)  ? {24'h0, dma_high_reg[rd_ch]} :
	                  (haddr[3:2] == SUB_START) ? {24'h0, dma_start_reg[rd_ch]} :
	                  (haddr[3:2] == SUB_END)   ? {24'h0, dma_end_reg[rd_ch]} :
	                  {4'h0, ch_addr[rd_ch], 13'h0, dma_done_reg[rd_ch],
	                   dma_src_reg[rd_ch], dma_en_reg[rd_ch]};
	assign rd_mux = (haddr[7:0] == OFS_DATA)   ? {24'h0, rx_buf_reg} :
	                (haddr[7:0] == OFS_STATUS) ? {23'h0, status} :
	                (haddr[7:0] == OFS_CTRL)   ? {23'h0, ctrl_reg} :
	                (haddr[7:0] == OFS_DIV_HI) ? {24'h0, div_hi_reg} :
	                (haddr[7:0] == OFS_DIV_LO) ? {24'h0, div_lo_reg} :
	                rd_dma ? dma_word : 32'h0;

	// Bus phase registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg  <= 32'h0;
		end else begin
			wr_pend_reg <= addr_ok & hwrite & in_map;
			if (addr_ok) wr_addr_reg <= haddr[7:0];
			if (addr_ok) hrdata_reg <= rd_go ? rd_mux : 32'h0;
		end
	end

	// Control and divisor registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_reg   <= CTRL_RESET;
			div_hi_reg <= DIV_RESET[15:8];
			div_lo_reg <= DIV_RESET[7:0];
		end else begin
			if (wr_ctrl) ctrl_reg <= hwdata[8:0];
			if (wr_div_hi) div_hi_reg <= hwdata[7:0];
			if (wr_div_lo) div_lo_reg <= hwdata[7:0];
		end
	end

	// Status view
	assign status[ST_RX_FULL] = rx_full_reg;
	assign status[ST_TX_RDY]  = ~tx_full_reg;
	assign status[ST_FRM]     = frm_reg;
	assign status[ST_PAR]     = par_reg;
	assign status[ST_OVR]     = ovr_reg;
	assign status[ST_BRK]     = brk_reg;
	assign status[ST_CTS]     = cts_n;
	assign status[ST_TX_BUSY] = (tx_state_reg != TX_IDLE);
	assign status[ST_BIT9]    = rx_bit9_reg;

	// ----------------------------------------------------------------
	// Baud divisor, one tick per sixteenth of a bit
	// ----------------------------------------------------------------
	assign baud_divisor = {div_hi_reg, div_lo_reg};
	assign div_last = (baud_divisor == 16'h0) ? 16'h0 : baud_divisor - 16'h1;
	assign tick     = (baud_cnt_reg >= div_last);

	always_ff @(posedge mclk) begin
		if (srst || tick) baud_cnt_reg <= 16'h0;
		else baud_cnt_reg <= baud_cnt_reg + 16'h1;
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	assign par_slot   = ctrl_reg[CTRL_PEN] | ctrl_reg[CTRL_MPEN];
	assign cts_ok     = ~ctrl_reg[CTRL_CTSE] | ~cts_n;
	assign tx_load    = (tx_state_reg == TX_IDLE) & tx_full_reg & ctrl_reg[CTRL_TEN] & cts_ok;
	assign tx_bit_end = tick && (tx_tcnt_reg == TICK_LAST);
	assign txd        = txd_reg;
	assign rts_n      = ctrl_reg[CTRL_RTS];
	assign irq_tx     = ctrl_reg[CTRL_TEN] & ~tx_full_reg;

	// Holding buffer; a write while full is dropped
	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_full_reg <= 1'b0;
			tx_buf_reg  <= 8'h00;
		end else if (wr_data && !tx_full_reg) begin
			tx_full_reg <= 1'b1;
			tx_buf_reg  <= hwdata[7:0];
		end else if (tx_load) begin
			tx_full_reg <= 1'b0;
		end
	end

	// Frame sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_state_reg  <= TX_IDLE;
			tx_shift_reg  <= 8'h00;
			tx_nine_reg   <= 1'b0;
			tx_tcnt_reg   <= 4'h0;
			tx_bitcnt_reg <= 3'h0;
			txd_reg       <= 1'b1;
		end else begin
			if (tick) tx_tcnt_reg <= tx_tcnt_reg + 4'h1;
			unique case (tx_state_reg)
				TX_IDLE: begin
					tx_tcnt_reg <= 4'h0;
					txd_reg     <= ~tx_load;
					if (tx_load) begin
						tx_shift_reg <= tx_buf_reg;
						tx_nine_reg  <= ctrl_reg[CTRL_MPEN] ? ctrl_reg[CTRL_MPBIT] :
						                parity_of(tx_buf_reg, ctrl_reg[CTRL_ODD]);
						tx_state_reg <= TX_START;
					end
				end
				TX_START: if (tx_bit_end) begin
					txd_reg       <= tx_shift_reg[0];
					tx_bitcnt_reg <= 3'h0;
					tx_state_reg  <= TX_DATA;
				end
				TX_DATA: if (tx_bit_end) begin
					if (tx_bitcnt_reg == BIT_LAST) begin
						txd_reg       <= par_slot ? tx_nine_reg : 1'b1;
						tx_bitcnt_reg <= 3'h0;
						tx_state_reg  <= par_slot ? TX_PAR : TX_STOP;
					end else begin
						txd_reg       <= tx_shift_reg[1];
						tx_shift_reg  <= tx_shift_reg >> 1;
						tx_bitcnt_reg <= tx_bitcnt_reg + 3'h1;
					end
				end
				TX_PAR: if (tx_bit_end) begin
					txd_reg      <= 1'b1;
					tx_state_reg <= TX_STOP;
				end
				TX_STOP: if (tx_bit_end) begin
					if (ctrl_reg[CTRL_STOP2] && tx_bitcnt_reg == 3'h0)
						tx_bitcnt_reg <= 3'h1;
					else
						tx_state_reg <= TX_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	assign rx_bit_end = tick && (rx_tcnt_reg == TICK_LAST);
	assign rx_take    = (rd_go && haddr[7:0] == OFS_DATA) | dma_fire[0] | dma_fire[1];
	assign irq_rx     = ctrl_reg[CTRL_REN] & rx_full_reg;

	// Frame sequencer, receive buffer and error flags
	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_state_reg  <= RX_IDLE;
			rx_shift_reg  <= 8'h00;
			rx_buf_reg    <= 8'h00;
			rx_tcnt_reg   <= 4'h0;
			rx_bitcnt_reg <= 3'h0;
			rx_nine_reg   <= 1'b0;
			rx_bit9_reg   <= 1'b0;
			rx_full_reg   <= 1'b0;
			frm_reg       <= 1'b0;
			par_reg       <= 1'b0;
			ovr_reg       <= 1'b0;
			brk_reg       <= 1'b0;
		end else begin
			if (rx_take) rx_full_reg <= 1'b0;
			if (wr_status) begin
				frm_reg <= frm_reg & ~hwdata[ST_FRM];
				par_reg <= par_reg & ~hwdata[ST_PAR];
				ovr_reg <= ovr_reg & ~hwdata[ST_OVR];
				brk_reg <= brk_reg & ~hwdata[ST_BRK];
			end
			if (tick) rx_tcnt_reg <= rx_tcnt_reg + 4'h1;
			unique case (rx_state_reg)
				RX_IDLE: begin
					rx_tcnt_reg <= 4'h0;
					if (ctrl_reg[CTRL_REN] && !rxd) rx_state_reg <= RX_START;
				end
				RX_START: if (tick && rx_tcnt_reg == TICK_MID) begin
					rx_tcnt_reg   <= 4'h0;
					rx_bitcnt_reg <= 3'h0;
					rx_state_reg  <= rxd ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rx_bit_end) begin
					rx_shift_reg  <= {rxd, rx_shift_reg[7:1]};
					rx_bitcnt_reg <= rx_bitcnt_reg + 3'h1;
					if (rx_bitcnt_reg == BIT_LAST)
						rx_state_reg <= par_slot ? RX_PAR : RX_STOP;
				end
				RX_PAR: if (rx_bit_end) begin
					rx_nine_reg  <= rxd;
					rx_state_reg <= RX_STOP;
				end
				RX_STOP: if (rx_bit_end) begin
					rx_state_reg <= rxd ? RX_IDLE : RX_BREAK;
					if (rx_full_reg && !rx_take) begin
						ovr_reg <= 1'b1;
					end else begin
						rx_buf_reg  <= rx_shift_reg;
						rx_full_reg <= 1'b1;
						rx_bit9_reg <= rx_nine_reg & ctrl_reg[CTRL_MPEN];
						if (!rxd) frm_reg <= 1'b1;
						if (ctrl_reg[CTRL_PEN] && !ctrl_reg[CTRL_MPEN] &&
						    parity_of(rx_shift_reg, ctrl_reg[CTRL_ODD]) != rx_nine_reg)
							par_reg <= 1'b1;
						if (!rxd && rx_shift_reg == 8'h00 && !(par_slot && rx_nine_reg))
							brk_reg <= 1'b1;
					end
				end
				RX_BREAK: if (rxd) rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// DMA channels: a and b serve the receiver, c the converter
	// ----------------------------------------------------------------
	// Requests, fixed priority a over b over c on the one RAM port
	assign dma_req[0]  = dma_en_reg[0] & dma_src_reg[0] & rx_full_reg & ~dma_load_reg[0];
	assign dma_req[1]  = dma_en_reg[1] & dma_src_reg[1] & rx_full_reg & ~dma_load_reg[1];
	assign dma_req[2]  = dma_en_reg[2] & conv_valid & ~dma_load_reg[2];
	assign dma_fire[0] = dma_req[0];
	assign dma_fire[1] = dma_req[1] & ~dma_req[0];
	assign dma_fire[2] = dma_req[2] & ~dma_req[0] & ~dma_req[1];
	assign conv_ready  = dma_fire[2];
	assign irq_dma     = dma_done_reg;
	assign mem_we      = mem_we_reg;
	assign mem_addr    = mem_addr_reg;
	assign mem_wdata   = mem_wdata_reg;

	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		dma_channel u_chan (
			.mclk       (mclk),
			.srst       (srst),
			.load       (dma_load_reg[c]),
			.advance    (dma_fire[c]),
			.start_addr ({dma_high_reg[c][3:0], dma_start_reg[c]}),
			.end_addr   ({dma_high_reg[c][7:4], dma_end_reg[c]}),
			.cur_addr   (ch_addr[c]),
			.at_end     (ch_end[c])
		);
	end

	// Channel set-up, buffer-full flags and pointer reload
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				dma_high_reg[c]  <= 8'h00;
				dma_start_reg[c] <= 8'h00;
				dma_end_reg[c]   <= 8'h00;
			end
			dma_en_reg   <= 3'h0;
			dma_src_reg  <= 3'h0;
			dma_done_reg <= 3'h0;
			dma_load_reg <= 3'h0;
		end else begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				dma_load_reg[c] <= wr_dma && wr_ch == 2'(c) && wr_addr_reg[3:2] != SUB_END;
				if (dma_fire[c] && ch_end[c]) dma_en_reg[c] <= 1'b0;
				if (wr_dma && wr_ch == 2'(c)) begin
					unique case (wr_addr_reg[3:2])
						SUB_HIGH:  dma_high_reg[c]  <= hwdata[7:0];
						SUB_START: dma_start_reg[c] <= hwdata[7:0];
						SUB_END:   dma_end_reg[c]   <= hwdata[7:0];
						SUB_CTRL: begin
							dma_en_reg[c]  <= hwdata[DCTL_EN];
							dma_src_reg[c] <= hwdata[DCTL_SRC];
						end
					endcase
				end
				// Buffer full wins over a same-cycle clear
				dma_done_reg[c] <= (dma_done_reg[c] & ~(wr_dma && wr_ch == 2'(c) &&
				                   wr_addr_reg[3:2] == SUB_CTRL && hwdata[DCTL_DONE])) |
				                   (dma_fire[c] & ch_end[c]);
			end
		end
	end

	// RAM write port
	always_ff @(posedge mclk) begin
		if (srst) begin
			mem_we_reg    <= 1'b0;
			mem_addr_reg  <= ADDR_RESET;
			mem_wdata_reg <= 8'h00;
		end else begin
			mem_we_reg    <= |dma_fire;
			mem_addr_reg  <= dma_fire[0] ? ch_addr[0] : dma_fire[1] ? ch_addr[1] : ch_addr[2];
			mem_wdata_reg <= dma_fire[2] ? conv_data : rx_buf_reg;
		end
	end

endmodule

// >>> uart_dma_top_assertions.sv
/* Port checker for uart_dma_top, bound below its endmodule.
   Assumes a baud divisor of at least one. */
`timescale 1ns/10ps
module uart_dma_top_checker (
	input wire logic        mclk,		// Clock
	input wire logic        srst,		// Reset
	input wire logic        hsel,		// Select
	input wire logic [31:0] haddr,		// Address
	input wire logic [1:0]  htrans,		// Transfer
	input wire logic        hwrite,		// Write
	input wire logic        hready,		// Ready in
	input wire logic [31:0] hrdata,		// Read data
	input wire logic        hreadyout,	// Ready out
	input wire logic        hresp,		// Response
	input wire logic        txd,		// Serial out
	input wire logic [2:0]  irq_dma,	// Buffer full
	input wire logic        conv_valid,	// Offer
	input wire logic [7:0]  conv_data,	// Byte
	input wire logic        conv_ready,	// Taken
	input wire logic        mem_we,		// Strobe
	input wire logic [7:0]  mem_wdata	// RAM data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// ----------------------------------------
	// Bus, line and RAM port checks
	// ----------------------------------------
	wire take = hsel && hready && htrans[1];
	sequence low_run; !txd [*8]; endsequence
	sequence high_run; txd [*8]; endsequence
	sequence conv_written; mem_we && mem_wdata == $past(conv_data); endsequence
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus wait or error");
	write_rdata_a: assert property (take && hwrite |=> hrdata == 32'h0)
		else $error("read data not zero after write");
	unmapped_zero_a: assert property (take && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	reset_idle_a: assert property ($fell(srst) |-> txd && !mem_we)
		else $error("not idle after reset");
	start_hold_a: assert property ($fell(txd) |-> low_run)
		else $error("low bit too short");
	stop_hold_a: assert property ($rose(txd) |-> high_run)
		else $error("high bit too short");
	conv_take_a: assert property (conv_ready |-> conv_valid ##1 conv_written)
		else $error("converter byte lost");
	dma_irq_a: assert property ($rose(irq_dma[0]) |-> mem_we || $past(mem_we))
		else $error("buffer full without write");
endmodule
bind uart_dma_top uart_dma_top_checker i_checker (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hrdata, .hreadyout, .hresp, .txd, .irq_dma, .conv_valid, .conv_data, .conv_ready,
	.mem_we, .mem_wdata);

// >>> serial_peer.sv
/* Serial terminal model: sends framed bytes on rxd, captures txd frames.
   Assumes eight data bits, a ninth bit slot and one stop bit. */
`timescale 1ns/10ps
module serial_peer #(
	parameter int BIT = 32	// Clock cycles per bit
) (
	input  wire logic mclk,	// Clock
	input  wire logic txd,	// From device
	output logic      rxd	// To device
);
	logic [8:0] got = 9'h000;	// Last frame, ninth bit on top
	int         got_cnt = 0;	// Frames captured

	// ----------------------------------------
	// Sender and receiver
	// ----------------------------------------
	initial rxd = 1'b1;

	// Start low, lsb first, ninth bit, high stop
	task automatic send(input logic [7:0] d, input logic p);
		logic [10:0] f;
		f = {1'b1, p, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge mclk);
		end
	endtask

	// Mid-bit sampling at the matched rate
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge mclk);
			got = {txd, got[8:1]};
		end
		repeat (BIT) @(posedge mclk);
		got_cnt++;
	end
endmodule

// >>> uart_dma_top_tb.sv
/* Self-checking bench for uart_dma_top with a serial peer.
   Assumes divisor 2, so a bit lasts 32 clock cycles. */
`timescale 1ns/10ps
module uart_dma_top_tb import uart_dma_pkg::*;;
	logic        mclk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, cts_n = 1'b0;
	logic        conv_valid = 1'b0, rxd, txd, rts_n, irq_rx, irq_tx, hreadyout, hresp;
	logic        conv_ready, mem_we;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  irq_dma;
	logic [7:0]  conv_data = 8'h00, mem_wdata, d, e;
	logic [11:0] mem_addr;
	logic [19:0] memq[$];
	int          num_errors = 0, comparisons = 0;

	// ----------------------------------------
	// Clock, design, peer and RAM monitor
	// ----------------------------------------
	always #25 mclk = ~mclk;
	uart_dma_top i_uart_dma_top (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxd, .txd, .cts_n, .rts_n,
		.irq_rx, .irq_tx, .irq_dma, .conv_valid, .conv_data, .conv_ready, .mem_we, .mem_addr,
		.mem_wdata);
	serial_peer #(.BIT(32)) i_serial_peer (.mclk, .txd, .rxd);
	always @(posedge mclk) begin
		if (mem_we === 1'b1) begin
			memq.push_back({mem_addr, mem_wdata});
		end
	end

	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, x);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d, comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// One clock with a bounded count
	task automatic tick(inout int n);
		@(posedge mclk);
		n++;
		if (n > 2000) begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic wait_hi(ref logic c);
		int n;
		n = 0;
		tick(n);
		while (c !== 1'b1) tick(n);
	endtask
	// Single AHB-Lite word transfer, read data into r
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_hi(hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_hi(hreadyout);
		r = hrdata;
		@(posedge mclk);
	endtask
	function automatic logic par(input logic [7:0] v, input logic odd);
		return ^v ^ odd;
	endfunction
	// Send d held by clear-to-send, then check the frame seen
	task automatic tx_check(input logic b9);
		int n0;
		int n;
		n0 = i_serial_peer.got_cnt;
		n = 0;
		cts_n <= 1'b1;
		bus(1, OFS_DATA, d);
		repeat (60) @(posedge mclk);
		chk(txd, 1'b1);
		bus(0, OFS_STATUS, 0);
		chk(r[7], 1'b0);
		cts_n <= 1'b0;
		while (i_serial_peer.got_cnt == n0) tick(n);
		chk(i_serial_peer.got, {b9, d});
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(64));
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		chk(rts_n, 1'b1);
		bus(0, OFS_CTRL, 0);
		chk(r, 32'h100);
		bus(1, OFS_DIV_LO, 2);
		for (int odd = 0; odd < 2; odd++) begin
			bus(1, OFS_CTRL, 32'h127 | odd << 3);
			d = 8'($urandom);
			tx_check(par(d, odd[0]));
			chk(irq_tx, 1'b1);
			d = 8'($urandom);
			i_serial_peer.send(d, par(d, odd[0]));
			chk(irq_rx, 1'b1);
			bus(0, OFS_DATA, 0);
			chk(r, d);
			bus(0, OFS_STATUS, 0);
			chk(r[5:2], 4'h0);
			i_serial_peer.send(d, ~par(d, odd[0]));
			bus(0, OFS_STATUS, 0);
			chk(r[3], 1'b1);
			bus(0, OFS_DATA, 0);
			bus(1, OFS_STATUS, 32'h3C);
		end
		d = 8'($urandom);
		e = 8'($urandom);
		i_serial_peer.send(d, par(d, 1'b1));
		i_serial_peer.send(e, par(e, 1'b1));
		bus(0, OFS_STATUS, 0);
		chk(r[4], 1'b1);
		bus(0, OFS_DATA, 0);
		chk(r, d);
		bus(1, OFS_STATUS, 32'h3C);
		bus(1, OFS_CTRL, 32'h1F1);
		d = 8'($urandom);
		tx_check(1'b1);
		i_serial_peer.send(d, 1'b0);
		chk(irq_rx, 1'b0);
		bus(0, OFS_STATUS, 0);
		chk(r[0], 1'b0);
		bus(1, OFS_CTRL, 32'h12F);
		bus(1, 32'h20, 32'hDD);
		bus(1, 32'h24, 0);
		bus(1, 32'h28, 3);
		bus(1, 32'h2C, 3);
		// Two buffers in turn, swapped once the first is full
		for (int i = 0; i < 8; i++) begin
			if (i == 4) begin
				chk(irq_dma, 3'h1);
				bus(1, OFS_CTRL, 32'h02F);
				chk(rts_n, 1'b0);
				bus(1, 32'h24, 4);
				bus(1, 32'h28, 7);
				bus(1, 32'h2C, 7);
				bus(1, OFS_CTRL, 32'h12F);
			end
			d = 8'($urandom);
			i_serial_peer.send(d, par(d, 1'b1));
			chk(memq.pop_front(), {12'hD00 + i[11:0], d});
		end
		chk(irq_dma, 3'h1);
		bus(1, 32'h40, 0);
		bus(1, 32'h44, 32'h10);
		bus(1, 32'h48, 32'h10);
		bus(1, 32'h4C, 1);
		conv_data <= 8'($urandom);
		conv_valid <= 1'b1;
		wait_hi(conv_ready);
		conv_valid <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(memq.pop_front(), {12'h010, conv_data});
		chk(irq_dma, 3'h5);
		bus(0, 32'h100, 0);
		chk(r, 0);
		print_verdict();
	end
endmodule
